// >>> logic/sar_adc_sequencer.sv
// adc sequencer with axi4-lite register access
// Functional notes
// - result bits split high and low registers
// - done flag reads one after completion
// - reading high result clears done flag
// - busy set at start, cleared finish/standby
// - low four status bits undefined, ignore
// - mode single: start bit begins conversion
// - completion stores result, sets done, interrupts
// - start bit clears once conversion begins
// - mode repeat: start bit begins continuous conversions
// - repeat mode restarts automatically on completion
// - disable mode halts, partial result dropped
// - new start clears done, keeps old result
// - standby aborts, resets controls, clears results
// - no automatic resume after standby
// - standby disconnects analog reference
// - mode field decode 00/01/10/11
// - time select codes map to cycles
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int res_bits = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby, // stop or slow mode active
  input wire logic comp_high, // comparator: input above trial level
  output logic [res_bits-1:0] dac_code, // trial code to ladder
  output logic [3:0] channel_sel, // analog mux select
  output logic analog_input_disable, // analog inputs off
  output logic ref_connect, // ladder reference switch
  output logic sample_hold, // hold while converting
  output logic conversion_done_interrupt // one cycle pulse at completion
);
  // block outline:
  //   register bus slave, one write and one read in flight
  //   two control registers, wiped while standby is high
  //   timer and bit trial engine share the start strobe
  //   result and status packed into two byte registers
  //   interrupt pulse one cycle after each completion
  // state types
  typedef enum logic [1:0] {
    wr_idle,
    wr_resp
  } wr_state_t;

  // registers and internal strobes
  logic [7:0] ctrl_one_r; // converter_control_one
  logic [7:0] ctrl_two_r; // converter_control_two
  logic [res_bits-1:0] result_r; // held conversion result
  logic done_r; // conversion_done_flag
  logic irq_r; // interrupt pulse
  logic aw_held_r; // write address captured
  logic w_held_r; // write data captured
  logic [11:0] aw_addr_r; // captured write address
  logic [7:0] w_data_r; // captured write data low byte
  logic w_strb_r; // lane zero strobe
  logic [1:0] bresp_r; // write response code
  wr_state_t wr_state_r; // write channel state
  logic rvalid_r; // read answer pending
  logic [31:0] rdata_r; // read data
  logic [1:0] rresp_r; // read response
  logic do_write; // write commits this cycle
  logic do_read; // read accepted this cycle
  logic mode_ok; // mode allows conversion
  logic conv_start; // start a conversion now
  logic conv_abort; // abandon the running one
  logic running; // timer busy
  logic finish; // timer done this cycle
  logic [res_bits-1:0] trial; // sar trial code
  mode_t mode; // decoded mode

  // mode field sits in bits 6 and 5
  assign mode = mode_t'(ctrl_one_r[mode_lo_pos+1:mode_lo_pos]);
  // reserved mode starts no conversion but, unlike disabled, does not abort a running one
  // decode which modes convert
  always_comb begin
    unique case (mode)
      mode_single: mode_ok = 1'b1;
      mode_repeat: mode_ok = 1'b1;
      mode_disable: mode_ok = 1'b0;
      mode_reserved: mode_ok = 1'b0;
    endcase
  end

  // a pending start bit waits while the timer runs
  // repeat restarts at the completion edge, no idle gap
  // start on request bit, or automatically after each repeat completion
  assign conv_start = !standby && mode_ok && !running && ctrl_one_r[start_bit_pos]
    || (!standby && mode == mode_repeat && finish);
  // disable mode or standby kills an active conversion
  assign conv_abort = running && (mode == mode_disable || standby);

  // timer sets the conversion length and the busy time
  conv_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(conv_start),
    .abort(conv_abort),
    .time_sel(ctrl_two_r[time_lo_pos+2:time_lo_pos]),
    .running(running),
    .finish(finish)
  );

  // bit trial engine, one step per cycle from the msb
  sar_step #(.res_bits(res_bits)) u_sar (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(conv_start),
    .comp_high(comp_high),
    .trial(trial)
  );

  // write path hazards:
  //   address and data may arrive in either order
  //   ready drops once a half is held, so nothing is overrun
  //   commit happens one cycle after both halves are held
  //   response stands until the master takes it
  // write channel: accept address and data in either order
  assign s_axi_awready = (wr_state_r == wr_idle) && !aw_held_r;
  assign s_axi_wready = (wr_state_r == wr_idle) && !w_held_r;
  assign do_write = (wr_state_r == wr_idle) && aw_held_r && w_held_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
      wr_state_r <= wr_idle;
      bresp_r <= resp_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
      end
      unique case (wr_state_r)
        wr_idle: begin
          if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            wr_state_r <= wr_resp;
            // result registers are read only; unmapped gives slverr
            if (aw_addr_r == ctrl_one_addr || aw_addr_r == ctrl_two_addr
                || aw_addr_r == result_low_addr || aw_addr_r == result_high_addr) begin
              bresp_r <= resp_okay;
            end else begin
              bresp_r <= resp_slverr;
            end
          end
        end
        wr_resp: begin
          if (s_axi_bready) begin
            wr_state_r <= wr_idle;
          end
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_r == wr_resp);
  assign s_axi_bresp = bresp_r;

  // start bit handling:
  //   a write in the start cycle wins over the self clear
  //   the bit clears at the edge that starts the timer
  //   standby wipes the register and blocks writes
  // control register one: software fields, self-clearing start bit
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      ctrl_one_r <= ctrl_one_rst;
    end else begin
      if (do_write && w_strb_r && aw_addr_r == ctrl_one_addr) begin
        ctrl_one_r <= w_data_r;
      end
      if (conv_start && !(do_write && w_strb_r && aw_addr_r == ctrl_one_addr)) begin
        ctrl_one_r[start_bit_pos] <= 1'b0;
      end
    end
  end

  // bit 4 is tied high and bit 0 low whatever is written
  // bits 7 and 6 hold nothing and read zero here
  // control register two: bit 4 reads one, bit 0 zero
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      ctrl_two_r <= ctrl_two_rst;
    end else if (do_write && w_strb_r && aw_addr_r == ctrl_two_addr) begin
      ctrl_two_r <= {2'b00, w_data_r[5], 1'b1, w_data_r[3:1], 1'b0};
    end
  end

  // an abort never reaches the store; standby wipes older results
  // result hold: stored only on full completion
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      result_r <= '0;
    end else if (finish && !conv_abort) begin
      result_r <= trial;
    end
  end

  // priority: completion, then restart, then high result read
  // a completion in the same cycle as a clear keeps the flag set
  // done flag: completion beats clears, start and high read clear
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      done_r <= 1'b0;
    end else if (finish && !conv_abort) begin
      done_r <= 1'b1;
    end else if (conv_start) begin
      done_r <= 1'b0;
    end else if (do_read && s_axi_araddr == result_high_addr) begin
      done_r <= 1'b0;
    end
  end

  // registered for a clean pulse; rises with the flag, one cycle after finish
  // interrupt pulse at completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= finish && !conv_abort && !standby;
    end
  end

  // read path notes:
  //   address decoded at the handshake, data registered
  //   reading the high result clears done at that same edge
  //   status low nibble returns zero; software must ignore it
  //   unmapped addresses answer slverr with zero data
  // read channel: one cycle to answer
  assign s_axi_arready = !rvalid_r;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= resp_okay;
    end else if (do_read) begin
      rvalid_r <= 1'b1;
      rresp_r <= resp_okay;
      unique case (s_axi_araddr)
        // control registers read back as stored
        ctrl_one_addr: rdata_r <= {24'h000000, ctrl_one_r};
        ctrl_two_addr: rdata_r <= {24'h000000, ctrl_two_r};
        // low bits of status read as zero here
        result_low_addr: rdata_r <= {24'h000000, result_r[1:0], done_r, running, 4'h0};
        result_high_addr: rdata_r <= {24'h000000, result_r[res_bits-1:2]};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // analog side notes:
  //   the ladder is on only while converting unless forced on
  //   standby cuts the reference whatever the ladder bit says
  //   hold follows the busy flag for the whole conversion
  // analog side drive
  assign dac_code = trial;
  assign channel_sel = ctrl_one_r[3:0];
  assign analog_input_disable = ctrl_one_r[ain_dis_pos];
  assign sample_hold = running;
  assign ref_connect = !standby && (ctrl_two_r[ladder_pos] || running);
  assign conversion_done_interrupt = irq_r;
endmodule // sar_adc_sequencer

// >>> logic/sar_adc_pkg.sv
// shared constants for the sar adc sequencer
package sar_adc_pkg;
  // register byte offsets (printed offsets are indices; byte address is four times)
  localparam logic [7:0] ctrl_one_idx = 8'h1C;
  localparam logic [7:0] ctrl_two_idx = 8'h1D;
  localparam logic [7:0] result_low_idx = 8'h1E;
  localparam logic [7:0] result_high_idx = 8'h1F;
  localparam logic [11:0] ctrl_one_addr = {2'b00, ctrl_one_idx, 2'b00};
  localparam logic [11:0] ctrl_two_addr = {2'b00, ctrl_two_idx, 2'b00};
  localparam logic [11:0] result_low_addr = {2'b00, result_low_idx, 2'b00};
  localparam logic [11:0] result_high_addr = {2'b00, result_high_idx, 2'b00};
  // reset values
  localparam logic [7:0] ctrl_one_rst = 8'h10;
  localparam logic [7:0] ctrl_two_rst = 8'h10;
  // control one field positions
  localparam int start_bit_pos = 7;
  localparam int mode_lo_pos = 5;
  localparam int ain_dis_pos = 4;
  // control two field positions
  localparam int ladder_pos = 5;
  localparam int time_lo_pos = 1;
  // status field positions in the low result register
  localparam int done_pos = 5;
  localparam int busy_pos = 4;
  // conversion time counts in high_freq_clock cycles
  localparam logic [10:0] conv_cycles_39 = 11'd39;
  localparam logic [10:0] conv_cycles_78 = 11'd78;
  localparam logic [10:0] conv_cycles_156 = 11'd156;
  localparam logic [10:0] conv_cycles_312 = 11'd312;
  localparam logic [10:0] conv_cycles_624 = 11'd624;
  localparam logic [10:0] conv_cycles_1248 = 11'd1248;
  // operating modes
  typedef enum logic [1:0] {
    mode_disable = 2'b00,
    mode_single = 2'b01,
    mode_reserved = 2'b10,
    mode_repeat = 2'b11
  } mode_t;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage : sar_adc_pkg

// >>> logic/conv_timer.sv
// conversion length decoder and cycle counter
module conv_timer
  import sar_adc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic abort,
  input wire logic [2:0] time_sel,
  output logic running,
  output logic finish
);
  logic [10:0] count_r; // cycles left
  logic [10:0] length; // decoded length
  logic running_r; // counting

  // time select decode
  always_comb begin
    unique case (time_sel)
      3'b000: length = conv_cycles_39;
      3'b010: length = conv_cycles_78;
      3'b011: length = conv_cycles_156;
      3'b100: length = conv_cycles_312;
      3'b101: length = conv_cycles_624;
      3'b110: length = conv_cycles_1248;
      default: length = conv_cycles_1248; // reserved codes take the longest
    endcase
  end

  // down counter
  always_ff @(posedge aclk) begin
    if (!aresetn || abort) begin
      count_r <= 11'h000;
      running_r <= 1'b0;
    end else if (start) begin
      count_r <= length - 11'h001;
      running_r <= 1'b1;
    end else if (running_r) begin
      if (count_r == 11'h000) begin
        running_r <= 1'b0;
      end else begin
        count_r <= count_r - 11'h001;
      end
    end
  end

  assign running = running_r;
  assign finish = running_r && (count_r == 11'h000) && !abort;
endmodule // conv_timer

// >>> logic/sar_step.sv
// successive approximation bit trial engine
module sar_step
  import sar_adc_pkg::*;
#(
  parameter int res_bits = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic comp_high,
  output logic [res_bits-1:0] trial
);
  logic [res_bits-1:0] trial_r; // trial code toward dac
  logic [res_bits-1:0] mark_r; // bit under trial

  // walk from msb down, keep bit when comparator says input is higher
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trial_r <= '0;
      mark_r <= '0;
    end else if (start) begin
      trial_r <= {1'b1, {(res_bits-1){1'b0}}};
      mark_r <= {1'b1, {(res_bits-1){1'b0}}};
    end else if (mark_r != '0) begin
      // settle the bit under trial, raise the next lower one
      trial_r <= (trial_r & ~mark_r) | (comp_high ? mark_r : '0) | (mark_r >> 1);
      mark_r <= mark_r >> 1;
    end
  end

  assign trial = trial_r;
endmodule // sar_step

// >>> test/sar_adc_sequencer_properties.sv
// port checker for the adc sequencer
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic standby,
  input wire logic sample_hold,
  input wire logic ref_connect,
  input wire logic [3:0] channel_sel,
  input wire logic analog_input_disable,
  input wire logic conversion_done_interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // read request accepted
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // answer held with stable data
  sequence s_rd_keep;
    s_axi_rvalid && $stable(s_axi_rdata);
  endsequence
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_rd_keep)
    else $error("read answer dropped");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_standby_ref: assert property (standby |-> !ref_connect)
    else $error("reference connected in standby");
  a_standby_busy: assert property (standby |=> !sample_hold)
    else $error("busy kept in standby");
  a_standby_ctrl: assert property (standby |=> channel_sel == 4'h0 && analog_input_disable)
    else $error("controls not initialised");
  a_no_resume: assert property ($fell(standby) |-> !sample_hold [*2])
    else $error("conversion resumed alone");
  a_irq_pulse: assert property (conversion_done_interrupt |=> !conversion_done_interrupt)
    else $error("interrupt longer than one cycle");
  a_irq_cause: assert property (conversion_done_interrupt |-> $past(sample_hold) || $past(sample_hold, 2))
    else $error("interrupt without conversion");
endmodule // sar_adc_checker

bind sar_adc_sequencer sar_adc_checker u_sar_adc_checker (.*);

// >>> test/sar_adc_sequencer_tb_top.sv
// self-checking bench for the adc sequencer
module sar_adc_sequencer_tb_top
  import sar_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] all_m = 32'hFFFFFFFF;
  localparam logic [31:0] low_m = 32'h000000F0;
  logic aclk, aresetn = 1'b0, standby = 1'b0, comp_high;
  // response readies held high: every answer is taken when offered
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ref_connect, sample_hold, analog_input_disable, conversion_done_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0] dac_code, tgt = 10'h000, old;
  logic [3:0] channel_sel;
  logic [31:0] exp_q[$], msk_q[$]; // expected reads, oldest first
  logic [1:0] br_q[$], rr_q[$]; // expected response codes
  int mismatches = 0, checked = 0, n;
  int cyc[8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248}; // reserved codes run longest
  sar_adc_sequencer u_sar_adc_sequencer (.*);
  // analog input modelled as target code
  assign comp_high = (tgt >= dac_code);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // expected response code for an address
  function automatic logic [1:0] resp_for(input logic [11:0] a);
    logic hit;
    hit = a == ctrl_one_addr || a == ctrl_two_addr;
    hit = hit || a == result_low_addr || a == result_high_addr;
    return hit ? resp_okay : resp_slverr;
  endfunction
  // write: address and data offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    br_q.push_back(resp_for(a));
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
  endtask
  // read: note expectation, monitor compares
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    rr_q.push_back(resp_for(a));
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask
  task automatic wait_irq;
    do @(posedge aclk); while (!conversion_done_interrupt);
  endtask
  // read data, read response and write response monitor
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata & msk_q.pop_front(), exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk(32'(s_axi_rresp), 32'(rr_q.pop_front()));
    if (s_axi_bvalid && s_axi_bready) chk(32'(s_axi_bresp), 32'(br_q.pop_front()));
  end
  initial begin
    void'($urandom(98548));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ctrl_one_addr, 32'h10, all_m);
    rd(ctrl_two_addr, 32'h10, 32'hFFFFFF3F);
    rd(result_high_addr, 32'h0, all_m);
    rd(result_low_addr, 32'h0, low_m);
    rd(12'h000, 32'h0, all_m);
    $display("reset values test done");
    for (int t = 0; t < 8; t++) begin
      tgt <= 10'($urandom);
      wr(ctrl_one_addr, {4'h2, t[3:0]});
      wr(ctrl_two_addr, {2'b00, t[0], 1'b1, t[2:0], 1'b0});
      wr(ctrl_one_addr, {4'hA, t[3:0]});
      do @(posedge aclk); while (!sample_hold);
      chk(32'(ref_connect), 32'h1);
      n = 0;
      while (sample_hold) begin
        @(posedge aclk);
        n++;
      end
      chk(n, cyc[t]);
      chk(32'(channel_sel), t);
      rd(ctrl_one_addr, {4'h2, t[3:0]}, all_m);
      rd(result_low_addr, {tgt[1:0], 2'b10, 4'h0}, low_m);
      rd(result_high_addr, tgt[9:2], all_m);
      rd(result_low_addr, {tgt[1:0], 2'b00, 4'h0}, low_m);
    end
    $display("single conversion test done");
    wr(ctrl_one_addr, 8'hA0);
    wait_irq;
    old = tgt;
    tgt <= ~tgt;
    wr(ctrl_one_addr, 8'hA0);
    do @(posedge aclk); while (!sample_hold);
    rd(result_low_addr, {old[1:0], 2'b01, 4'h0}, low_m);
    rd(result_high_addr, old[9:2], all_m);
    wait_irq;
    rd(result_high_addr, tgt[9:2], all_m);
    $display("restart test done");
    wr(ctrl_two_addr, 8'h10);
    wr(ctrl_one_addr, 8'hE0);
    wait_irq;
    tgt <= ~tgt;
    wait_irq;
    wait_irq;
    chk(32'(sample_hold), 32'h1);
    rd(result_high_addr, tgt[9:2], all_m);
    rd(ctrl_one_addr, 32'h60, all_m);
    old = tgt;
    tgt <= ~tgt;
    repeat (10) @(posedge aclk);
    wr(ctrl_one_addr, 8'h00);
    repeat (2) @(posedge aclk);
    chk(32'(sample_hold), 32'h0);
    repeat (50) @(posedge aclk);
    rd(result_high_addr, old[9:2], all_m);
    $display("repeat and halt test done");
    wr(ctrl_two_addr, 8'h3C);
    wr(ctrl_one_addr, 8'hA3);
    repeat (20) @(posedge aclk);
    standby <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(ref_connect), 32'h0);
    chk(32'(sample_hold), 32'h0);
    rd(ctrl_one_addr, 32'h10, all_m);
    rd(ctrl_two_addr, 32'h10, 32'hFFFFFF3F);
    rd(result_high_addr, 32'h0, all_m);
    standby <= 1'b0;
    repeat (50) @(posedge aclk);
    chk(32'(sample_hold), 32'h0);
    wr(result_high_addr, 8'hFF);
    rd(result_high_addr, 32'h0, all_m);
    wr(12'h000, 8'h00);
    s_axi_wstrb <= 4'hE;
    wr(ctrl_one_addr, 8'hA5);
    s_axi_wstrb <= 4'hF;
    rd(ctrl_one_addr, 32'h10, all_m);
    $display("standby test done");
    finish_test;
  end
  // watchdog against a hang
  initial begin
    #300000;
    mismatches++;
    finish_test;
  end
endmodule // sar_adc_sequencer_tb_top
